// ==== src/tiks_teach_supervisor.sv ====
`timescale 1ns/100ps
module tiks_teach_supervisor #(
  parameter int UNLOCK_CYC = tiks_pkg::UNLOCK_CYC,
  parameter int ENTRY_CYC = tiks_pkg::ENTRY_CYC,
  parameter int TIMEOUT_CYC = tiks_pkg::TIMEOUT_CYC,
  parameter int STUCK_CYC = tiks_pkg::STUCK_CYC,
  parameter int CONFIRM_CYC = tiks_pkg::CONFIRM_CYC,
  parameter int BLINK_CYC = tiks_pkg::BLINK_CYC,
  parameter int DEBOUNCE_CYC = tiks_pkg::DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] buttonRaw,
  input wire logic actuatorPresentRaw,
  input wire logic detectReliableRaw,
  input wire logic [8:0] position,
  output logic [2:0] windowOutput,
  output logic [2:0] yellowLed,
  output logic powerGreen,
  output logic powerRed,
  output logic keylockActive,
  output logic storeWrite,
  output logic [1:0] storeIndex,
  output logic [8:0] storeStart,
  output logic [8:0] storeEnd
);
  logic [2:0] button;
  logic [2:0] buttonPrev;
  logic presA;
  logic present;
  logic relA;
  logic reliable;
  logic [29:0] holdCnt;
  logic [29:0] idleCnt;
  logic [29:0] confirmCnt;
  logic [29:0] blinkCnt;
  logic blink;
  logic holdUsed;
  logic lockRedFlag;
  tiks_pkg::tiks_state_e state;
  tiks_pkg::tiks_state_e next_state;
  logic [1:0] activeIdx;
  logic [8:0] tStart;
  logic [8:0] winStart [3];
  logic [8:0] winEnd [3];

  tiks_debounce #(
    .WIDTH(3),
    .STABLE_CYC(DEBOUNCE_CYC)
  ) u_debounce (
    .clk(clk),
    .resetn(resetn),
    .rawIn(buttonRaw),
    .clean(button)
  );

  function automatic logic [8:0] addWrap(input logic [8:0] a, input logic [8:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, tiks_pkg::FULL_TURN})
      s = s - {1'b0, tiks_pkg::FULL_TURN};
    return s[8:0];
  endfunction
  function automatic logic inWindow(input logic [8:0] p, input logic [8:0] s,
                                    input logic [8:0] e);
    if (s <= e)
      return (p >= s) && (p <= e);
    return (p >= s) || (p <= e);
  endfunction
  function automatic logic [1:0] indexOf(input logic [2:0] b);
    case (b)
      3'h1: return 2'h0;
      3'h2: return 2'h1;
      3'h4: return 2'h2;
      default: return tiks_pkg::NO_OUT;
    endcase
  endfunction
  wire [2:0] rise = button & ~buttonPrev;
  wire [2:0] fall = ~button & buttonPrev;
  wire anyEdge = |(rise | fall);
  wire anyHeld = |button;
  wire pairHeld = button == 3'h3;
  wire [1:0] soloIdx = indexOf(button);
  wire holdUnlock = pairHeld && holdCnt >= 30'(UNLOCK_CYC - 1) && !holdUsed;
  wire holdEntry = soloIdx != tiks_pkg::NO_OUT && holdCnt >= 30'(ENTRY_CYC - 1) && !holdUsed;
  wire holdStuck = anyHeld && holdCnt >= 30'(STUCK_CYC - 1);
  wire timedOut = idleCnt >= 30'(TIMEOUT_CYC - 1);
  wire sameRise = rise == (3'h1 << activeIdx);
  wire otherRise = (rise & ~(3'h1 << activeIdx)) != 3'h0;
  wire stableWin = (tStart == position) ? 1'b1 : 1'b0;
  wire [8:0] commitEnd = stableWin ? addWrap(tStart, tiks_pkg::MIN_WIDTH) : position;
  wire doCommit = state == tiks_pkg::TIKS_WAIT_END && sameRise && present;
  wire confirmDone = confirmCnt >= 30'(CONFIRM_CYC - 1);

  always_comb
  begin
    next_state = state;
    unique case (state)
      tiks_pkg::TIKS_IDLE:
        if (holdStuck)
          next_state = tiks_pkg::TIKS_STUCK;
        else if (holdEntry && !keylockActive && present)
          next_state = tiks_pkg::TIKS_WAIT_START;
      tiks_pkg::TIKS_WAIT_START:
        if (timedOut || otherRise)
          next_state = tiks_pkg::TIKS_IDLE;
        else if (sameRise && present)
          next_state = tiks_pkg::TIKS_CONFIRM;
      tiks_pkg::TIKS_CONFIRM:
        if (otherRise)
          next_state = tiks_pkg::TIKS_IDLE;
        else if (confirmDone)
          next_state = tiks_pkg::TIKS_WAIT_END;
      tiks_pkg::TIKS_WAIT_END:
        if (timedOut || otherRise || doCommit)
          next_state = tiks_pkg::TIKS_IDLE;
      tiks_pkg::TIKS_STUCK:
        if (!anyHeld)
          next_state = tiks_pkg::TIKS_IDLE;
      default:
        next_state = tiks_pkg::TIKS_IDLE;
    endcase
    if (holdStuck && next_state != tiks_pkg::TIKS_IDLE)
      next_state = tiks_pkg::TIKS_STUCK;
  end
  // Every button edge restarts both the hold timer and the inactivity timer.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      buttonPrev <= 3'h0;
      holdCnt <= 30'h00000000;
      idleCnt <= 30'h00000000;
      holdUsed <= 1'b0;
    end
    else
    begin
      buttonPrev <= button;
      holdCnt <= (anyEdge || !anyHeld) ? 30'h00000000 :
                 (holdStuck ? holdCnt : holdCnt + 30'h00000001);
      idleCnt <= (anyEdge || state == tiks_pkg::TIKS_IDLE) ? 30'h00000000 :
                 idleCnt + 30'h00000001;
      // One long hold fires one keylock toggle or teach entry only; any button edge, press or release, re-arms it for another.
      holdUsed <= (anyEdge || !anyHeld) ? 1'b0 : (holdUsed || holdUnlock || holdEntry);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      presA <= 1'b0;
      present <= 1'b0;
      relA <= 1'b0;
      reliable <= 1'b0;
      blinkCnt <= 30'h00000000;
      blink <= 1'b0;
      confirmCnt <= 30'h00000000;
    end
    else
    begin
      presA <= actuatorPresentRaw;
      present <= presA;
      relA <= detectReliableRaw;
      reliable <= relA;
      blinkCnt <= (blinkCnt >= 30'(BLINK_CYC - 1)) ? 30'h00000000 : blinkCnt + 30'h00000001;
      blink <= (blinkCnt >= 30'(BLINK_CYC - 1)) ? !blink : blink;
      confirmCnt <= (state == tiks_pkg::TIKS_CONFIRM) ? confirmCnt + 30'h00000001 :
                    30'h00000000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state <= tiks_pkg::TIKS_IDLE;
      activeIdx <= 2'h0;
      tStart <= 9'h000;
      keylockActive <= 1'b0;
      lockRedFlag <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == tiks_pkg::TIKS_IDLE && next_state == tiks_pkg::TIKS_WAIT_START)
        activeIdx <= soloIdx;
      if (state == tiks_pkg::TIKS_WAIT_START && next_state == tiks_pkg::TIKS_CONFIRM)
        tStart <= position;
      if (holdUnlock && state == tiks_pkg::TIKS_IDLE)
        keylockActive <= !keylockActive;
      // Red on a press while locked lasts until all buttons are released or the keylock clears.
      lockRedFlag <= anyHeld && keylockActive;
    end
  end

  // Stored windows change only on a committed third press.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      winStart[0] <= tiks_pkg::FACTORY_START0;
      winStart[1] <= tiks_pkg::FACTORY_START1;
      winStart[2] <= tiks_pkg::FACTORY_START2;
      winEnd[0] <= addWrap(tiks_pkg::FACTORY_START0, tiks_pkg::MIN_WIDTH);
      winEnd[1] <= addWrap(tiks_pkg::FACTORY_START1, tiks_pkg::MIN_WIDTH);
      winEnd[2] <= addWrap(tiks_pkg::FACTORY_START2, tiks_pkg::MIN_WIDTH);
      storeWrite <= 1'b0;
      storeIndex <= 2'h0;
      storeStart <= 9'h000;
      storeEnd <= 9'h000;
    end
    else
    begin
      storeWrite <= doCommit;
      if (doCommit)
      begin
        winStart[activeIdx] <= tStart;
        winEnd[activeIdx] <= commitEnd;
        storeIndex <= activeIdx;
        storeStart <= tStart;
        storeEnd <= commitEnd;
      end
    end
  end

  logic [2:0] next_window;
  logic [2:0] next_yellow;
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      next_window[i] = present && inWindow(position, winStart[i], winEnd[i]);
    next_yellow = next_window;
    unique case (state)
      tiks_pkg::TIKS_WAIT_START,
      tiks_pkg::TIKS_WAIT_END:
        next_yellow[activeIdx] = blink;
      tiks_pkg::TIKS_CONFIRM:
        next_yellow[activeIdx] = 1'b1;
      tiks_pkg::TIKS_STUCK:
        next_yellow = button & {3{blink}};
      default:
        next_yellow = next_window;
    endcase
  end
  // Loss of the actuator, or an unreliable reading, wins red over green except in TIKS_STUCK, where red blinks instead.
  wire redSteady = !present || !reliable || lockRedFlag;
  wire next_red = (state == tiks_pkg::TIKS_STUCK) ? blink : redSteady;
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      windowOutput <= 3'h0;
      yellowLed <= 3'h0;
      powerRed <= 1'b0;
      powerGreen <= 1'b1;
    end
    else
    begin
      windowOutput <= next_window;
      yellowLed <= next_yellow;
      powerRed <= next_red;
      powerGreen <= !next_red;
    end
  end
  property p_entry_needs_actuator;
    @(posedge clk) disable iff (!resetn)
    (state == tiks_pkg::TIKS_IDLE && next_state == tiks_pkg::TIKS_WAIT_START) |-> present;
  endproperty
  a_entry_needs_actuator: assert property (p_entry_needs_actuator)
    else $error("Teach mode entered without actuator.");
  property p_no_entry_locked;
    @(posedge clk) disable iff (!resetn)
    (state == tiks_pkg::TIKS_IDLE && keylockActive) |=> state != tiks_pkg::TIKS_WAIT_START;
  endproperty
  a_no_entry_locked: assert property (p_no_entry_locked)
    else $error("Teach mode entered while locked.");
  property p_entry_hold;
    @(posedge clk) disable iff (!resetn)
    (state == tiks_pkg::TIKS_IDLE && next_state == tiks_pkg::TIKS_WAIT_START)
      |-> holdCnt >= 30'(ENTRY_CYC - 1);
  endproperty
  a_entry_hold: assert property (p_entry_hold)
    else $error("Teach mode entered before hold time.");
  property p_lock_hold;
    @(posedge clk) disable iff (!resetn)
    $changed(keylockActive) |-> $past(pairHeld) && $past(holdCnt) >= 30'(UNLOCK_CYC - 1);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("Keylock changed without full joint hold.");
  property p_timeout;
    @(posedge clk) disable iff (!resetn)
    (state == tiks_pkg::TIKS_WAIT_END && timedOut && !anyEdge) |=>
      state == tiks_pkg::TIKS_IDLE;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("Teach mode survived timeout.");
  property p_windows_kept;
    @(posedge clk) disable iff (!resetn)
    !doCommit |=> $stable(winStart[0]) && $stable(winStart[1]) && $stable(winStart[2])
      && $stable(winEnd[0]) && $stable(winEnd[1]) && $stable(winEnd[2]);
  endproperty
  a_windows_kept: assert property (p_windows_kept)
    else $error("Window changed without commit.");
  sequence s_commit;
    doCommit ##1 storeWrite;
  endsequence
  property p_commit;
    @(posedge clk) disable iff (!resetn)
    doCommit |-> s_commit;
  endproperty
  a_commit: assert property (p_commit)
    else $error("Commit did not pulse store write.");
  property p_red_lost;
    @(posedge clk) disable iff (!resetn)
    (!present && state != tiks_pkg::TIKS_STUCK) |=> powerRed && !powerGreen;
  endproperty
  a_red_lost: assert property (p_red_lost)
    else $error("Power LED not red with actuator lost.");
  property p_out_lost;
    @(posedge clk) disable iff (!resetn)
    !present |=> windowOutput == 3'h0;
  endproperty
  a_out_lost: assert property (p_out_lost)
    else $error("Output active with actuator lost.");
endmodule

// ==== src/tiks_pkg.sv ====
package tiks_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int UNLOCK_MS = 3000;
  localparam int ENTRY_MS = 2000;
  localparam int TIMEOUT_MS = 60000;
  localparam int STUCK_MS = 15000;
  localparam int CONFIRM_MS = 2000;
  localparam int BLINK_MS = 250;
  localparam int DEBOUNCE_MS = 10;
  localparam int UNLOCK_CYC = UNLOCK_MS * (CLK_HZ / 1000);
  localparam int ENTRY_CYC = ENTRY_MS * (CLK_HZ / 1000);
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int STUCK_CYC = STUCK_MS * (CLK_HZ / 1000);
  localparam int CONFIRM_CYC = CONFIRM_MS * (CLK_HZ / 1000);
  localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int POS_W = 9;
  localparam int TIME_W = 30;
  localparam logic [8:0] FACTORY_START0 = 9'h078;
  localparam logic [8:0] FACTORY_START1 = 9'h0F0;
  localparam logic [8:0] FACTORY_START2 = 9'h000;
  localparam logic [8:0] MIN_WIDTH = 9'h005;
  localparam logic [8:0] FULL_TURN = 9'h168;
  localparam logic [1:0] NO_OUT = 2'h3;
  typedef enum logic [2:0]
  {
    TIKS_IDLE = 3'h0,
    TIKS_WAIT_START = 3'h1,
    TIKS_CONFIRM = 3'h3,
    TIKS_WAIT_END = 3'h2,
    TIKS_STUCK = 3'h6
  } tiks_state_e;
endpackage

// ==== src/tiks_debounce.sv ====
`timescale 1ns/100ps
module tiks_debounce #(
  parameter int WIDTH = 3,
  parameter int STABLE_CYC = tiks_pkg::DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] clean
);
  logic [WIDTH-1:0] syncA;
  logic [WIDTH-1:0] syncB;
  logic [WIDTH-1:0] prevB;
  logic [19:0] stableCnt;
  wire changed = syncB != prevB;
  wire settled = stableCnt >= 20'(STABLE_CYC - 1);

  // Two flops before any logic sees the pins; clean moves only after a quiet interval.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      syncA <= '0;
      syncB <= '0;
      prevB <= '0;
      stableCnt <= 20'h00000;
      clean <= '0;
    end
    else
    begin
      syncA <= rawIn;
      syncB <= syncA;
      prevB <= syncB;
      stableCnt <= changed ? 20'h00000 : (settled ? stableCnt : stableCnt + 20'h00001);
      if (settled)
        clean <= prevB;
    end
  end
endmodule

// ==== verification/tiks_operator_model.sv ====
`timescale 1ns/100ps
module tiks_operator_model (
  input wire logic clk,
  input wire logic [2:0] pressCmd,
  input wire logic presentCmd,
  input wire logic reliableCmd,
  input wire logic [8:0] angleCmd,
  output logic [2:0] buttonRaw,
  output logic actuatorPresentRaw,
  output logic detectReliableRaw,
  output logic [8:0] position
);
  // Commands are sampled on the edge and applied a fixed delay later, so they never race the bench.
  // Without an actuator the angle reading is meaningless, so it changes every cycle.
  always @(posedge clk)
  begin
    buttonRaw <= #10 pressCmd;
    actuatorPresentRaw <= #10 presentCmd;
    detectReliableRaw <= #10 reliableCmd;
    position <= #10 (presentCmd ? angleCmd : ~position);
  end
endmodule

// ==== verification/teach_in_keylock_supervisor_test.sv ====
`timescale 1ns/100ps
module teach_in_keylock_supervisor_test;
  localparam int BL = 4;
  localparam int UNL = 40;
  localparam int ENT = 30;
  localparam int TMO = 200;
  localparam int STK = 300;
  localparam int CNF = 20;
  localparam int DEB = 2;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] pressCmd = 3'h0;
  logic presentCmd = 1'b1;
  logic reliableCmd = 1'b1;
  logic [8:0] angleCmd = 9'h0C8;
  logic [2:0] buttonRaw;
  logic actuatorPresentRaw;
  logic detectReliableRaw;
  logic [8:0] position;
  logic [2:0] windowOutput;
  logic [2:0] yellowLed;
  logic powerGreen;
  logic powerRed;
  logic keylockActive;
  logic storeWrite;
  logic [1:0] storeIndex;
  logic [8:0] storeStart;
  logic [8:0] storeEnd;
  logic [1:0] capIdx;
  logic [8:0] capStart;
  logic [8:0] capEnd;
  logic [8:0] lo [3] = '{9'h078, 9'h0F0, 9'h000};
  logic [8:0] hi [3] = '{9'h07D, 9'h0F5, 9'h005};
  logic [31:0] seed = 32'h0000826A;
  logic [8:0] s;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  int stores = 0;
  int keep;

  tiks_operator_model u_tiks_operator_model (.clk(clk), .pressCmd(pressCmd),
    .presentCmd(presentCmd), .reliableCmd(reliableCmd), .angleCmd(angleCmd),
    .buttonRaw(buttonRaw), .actuatorPresentRaw(actuatorPresentRaw),
    .detectReliableRaw(detectReliableRaw), .position(position));

  // Short counts keep the run small; the waits below are fixed cycle counts sized to fit them, only flashCheck scales from BL.
  tiks_teach_supervisor #(.UNLOCK_CYC(UNL), .ENTRY_CYC(ENT), .TIMEOUT_CYC(TMO),
    .STUCK_CYC(STK), .CONFIRM_CYC(CNF), .BLINK_CYC(BL), .DEBOUNCE_CYC(DEB))
  u_tiks_teach_supervisor (.clk(clk), .resetn(resetn), .buttonRaw(buttonRaw),
    .actuatorPresentRaw(actuatorPresentRaw), .detectReliableRaw(detectReliableRaw),
    .position(position), .windowOutput(windowOutput), .yellowLed(yellowLed),
    .powerGreen(powerGreen), .powerRed(powerRed), .keylockActive(keylockActive),
    .storeWrite(storeWrite), .storeIndex(storeIndex), .storeStart(storeStart),
    .storeEnd(storeEnd));

  initial
  begin
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] nextRand(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic pick(input int sel);
    return (sel == 3) ? powerRed : yellowLed[sel];
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (storeWrite === 1'b1)
    begin
      stores++;
      capIdx = storeIndex;
      capStart = storeStart;
      capEnd = storeEnd;
    end
    if (cycles == 12000)
    begin
      err_total++;
      conclude();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check({8'h00, got}, {8'h00, exp});
  endtask

  task automatic hold(input logic [2:0] m, input int n);
    pressCmd = m;
    cyc(n);
  endtask

  task automatic rel();
    pressCmd = 3'h0;
    cyc(12);
  endtask

  task automatic flashCheck(input int sel, input logic exp);
    logic prev;
    int flips;
    flips = 0;
    prev = pick(sel);
    repeat (6 * BL)
    begin
      cyc(1);
      if (pick(sel) !== prev)
        flips++;
      prev = pick(sel);
    end
    check1(flips >= 2, exp);
  endtask

  task automatic winCheck();
    logic [8:0] pts [4];
    logic [2:0] e;
    pts = '{lo[0] + 9'h002, lo[1] + 9'h002, lo[2] + 9'h002, 9'h15E};
    foreach (pts[p])
    begin
      angleCmd = pts[p];
      cyc(5);
      for (int i = 0; i < 3; i++)
        e[i] = pts[p] > lo[i] && pts[p] < hi[i];
      check({6'h00, windowOutput}, {6'h00, e});
    end
  endtask

  task automatic teach(input int idx, input logic [8:0] st, input logic [8:0] en);
    hold(3'h1 << idx, 40);
    flashCheck(idx, 1'b1);
    rel();
    angleCmd = st;
    hold(3'h1 << idx, 8);
    check1(yellowLed[idx], 1'b1);
    rel();
    cyc(20);
    angleCmd = en;
    hold(3'h1 << idx, 8);
    rel();
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    #10;
    resetn = 1'b1;
    cyc(8);
    check({5'h00, keylockActive, powerGreen, powerRed, storeWrite}, 9'h004);
    winCheck();
    angleCmd = 9'h07A;
    presentCmd = 1'b0;
    cyc(8);
    check1(powerRed, 1'b1);
    check({6'h00, windowOutput}, 9'h000);
    presentCmd = 1'b1;
    reliableCmd = 1'b0;
    cyc(8);
    check1(powerRed, 1'b1);
    reliableCmd = 1'b1;
    cyc(8);
    check1(powerRed, 1'b0);
    $display("test indication done");
    angleCmd = 9'h15E;
    hold(3'h1, 20);
    rel();
    flashCheck(0, 1'b0);
    hold(3'h1, 40);
    flashCheck(0, 1'b1);
    rel();
    cyc(250);
    flashCheck(0, 1'b0);
    $display("test entry done");
    for (int k = 0; k < 3; k++)
    begin
      seed = nextRand(seed);
      s = 9'd20 + 9'(k * 80) + {3'h0, seed[5:0]};
      keep = stores;
      teach(k, s, s + 9'h00A);
      check(9'(stores - keep), 9'h001);
      check({7'h00, capIdx}, 9'(k));
      check(capStart, s);
      check(capEnd, s + 9'h00A);
      flashCheck(k, 1'b0);
      lo[k] = s;
      hi[k] = s + 9'h00A;
      winCheck();
    end
    // No movement between the start and end presses must still give the minimum window.
    s = lo[0];
    keep = stores;
    teach(0, s, s);
    check(9'(stores - keep), 9'h001);
    check(capStart, s);
    check(capEnd, s + tiks_pkg::MIN_WIDTH);
    hi[0] = s + tiks_pkg::MIN_WIDTH;
    winCheck();
    $display("test commit done");
    keep = stores;
    hold(3'h2, 40);
    rel();
    hold(3'h2, 8);
    rel();
    cyc(250);
    flashCheck(1, 1'b0);
    hold(3'h4, 40);
    rel();
    hold(3'h4, 8);
    rel();
    hold(3'h1, 8);
    rel();
    hold(3'h4, 8);
    rel();
    flashCheck(2, 1'b0);
    check(9'(stores - keep), 9'h000);
    winCheck();
    $display("test abort done");
    hold(3'h1, 40);
    rel();
    presentCmd = 1'b0;
    cyc(8);
    check1(powerRed, 1'b1);
    presentCmd = 1'b1;
    cyc(250);
    presentCmd = 1'b0;
    hold(3'h1, 40);
    check1(powerRed, 1'b1);
    flashCheck(0, 1'b0);
    rel();
    presentCmd = 1'b1;
    cyc(12);
    $display("test actuator done");
    hold(3'h3, 20);
    rel();
    check1(keylockActive, 1'b0);
    hold(3'h3, 50);
    rel();
    check1(keylockActive, 1'b1);
    hold(3'h1, 40);
    check1(powerRed, 1'b1);
    flashCheck(0, 1'b0);
    rel();
    hold(3'h3, 50);
    rel();
    check1(keylockActive, 1'b0);
    $display("test keylock done");
    keep = stores;
    hold(3'h4, 340);
    flashCheck(2, 1'b1);
    flashCheck(3, 1'b1);
    rel();
    check({7'h00, powerGreen, powerRed}, 9'h002);
    check(9'(stores - keep), 9'h000);
    $display("test stuck done");
    cyc(250);
    conclude();
  end
endmodule
